// ---- rtl/ispb_host_ctrl.sv ----
/*
  spi master controller that drives a pulse bridge through its spi and strap pins.
  software reaches the controller over apb; the bridge sits in the master role and
  its data-out toward this block is asynchronous, so it is synchronised first.
*/
// Local design decisions: the APB slave port and the placing of the registers.

// Contract
// RQ1: bridge sends each chip-select change as a long bipolar pulse, halves 120-180 ns.
// RQ2: bridge sends each data bit as a short bipolar pulse, halves 40-60 ns.
// RQ3: latching clock edges at least 0.5 us apart, 5 us in slow mode.
// RQ4: bridge starts a data pulse within 50 ns of a latching edge.
// RQ5: bridge starts a long pulse within 55 ns of a chip-select change.
// RQ6: bridge releases data-out high within 55 ns after chip select rises.
// RQ7: bridge presents returned bit within 55 ns after the non-latching edge.
// RQ8: chip select stays high at least 2.0 us (0.6 us slow clocks) between frames.
// RQ9: wait at least 1 us after last latching edge before raising chip select.
// RQ10: wait at least 1 us after chip select falls before first latching edge.
// RQ11: far bridge makes latching edge 110-185 ns after data pulse, slower in slow mode.
// RQ12: far bridge sends returned bit 115-190 ns after non-latching edge.
// RQ13: far bridge with phase one drives non-latching edge 90-160 ns after select falls.
// RQ14: far bridge sends first returned pulse 200-345 ns after select falls.
// RQ15: far bridge with phase one drives closing latching edge after select rises.
// RQ16: far bridge releases slave data line within 35 ns after select rises.
// RQ17: with enable low the bridge idles after 5.7 ms and wakes within 8 us.
// RQ18: role-select high puts the bridge in the master role, low in slave role.
// RQ19: use slow mode at 200 kHz or less, fast timing above that rate.
// RQ20: receiving bridge decodes pulse polarity into select and data levels.
module ispb_host_ctrl (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o,
  output logic role_select_o,
  output logic slow_o,
  output logic clock_phase_select_o,
  output logic clock_polarity_select_o,
  output logic enable_o
);

  // ****************************************
  // declarations
  // ****************************************
  ispb_pkg::ispb_ctrl_s ctrl_reg;
  ispb_pkg::ispb_spi_s spi_reg;
  ispb_pkg::ispb_state_e state_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [31:0] txdata_reg;
  logic [ispb_pkg::TMR_W-1:0] tmr_reg;
  logic [5:0] edge_reg;
  logic done_reg;
  logic miso_meta_reg;
  logic miso_sync_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic apb_fire;
  logic apb_wr;
  logic start;
  logic tmr_zero;
  logic leading;
  logic latch;
  logic last_edge;
  logic [ispb_pkg::TMR_W-1:0] half_cyc;
  logic [5:0] edge_total_m1;

  // ****************************************
  // apb slave
  // ****************************************
  // transfer completes at the edge where pready is high
  assign apb_fire = psel_i & penable_i & pready_reg;
  assign apb_wr = apb_fire & pwrite_i;
  assign start = apb_wr && paddr_i == ispb_pkg::TXDATA_OFS && state_reg == ispb_pkg::ST_IDLE;

  // one wait state, answer on the second access cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel_i & penable_i & ~pready_reg;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      if (psel_i && penable_i && !pready_reg) begin
        unique case (paddr_i)
          ispb_pkg::CTRL_OFS: prdata_reg <= {19'h0_0000, ctrl_reg.len_m1, 3'h0, ctrl_reg.role,
            ctrl_reg.en, ctrl_reg.clock_polarity_select, ctrl_reg.clock_phase_select, ctrl_reg.slow};
          ispb_pkg::TXDATA_OFS: prdata_reg <= txdata_reg;
          ispb_pkg::RXDATA_OFS: prdata_reg <= rx_reg;
          ispb_pkg::STATUS_OFS: prdata_reg <= {30'h0000_0000, done_reg,
            state_reg != ispb_pkg::ST_IDLE};
          default: pslverr_reg <= 1'b1; // unmapped address
        endcase
      end
    end
  end

  // control register, frozen while a frame runs
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // length field and the five strap bits taken from the reset word
      ctrl_reg <= ispb_pkg::ispb_ctrl_s'({ispb_pkg::CTRL_RESET[ispb_pkg::CTRL_LEN_LSB +: 5],
        ispb_pkg::CTRL_RESET[4:0]});
    end else if (apb_wr && paddr_i == ispb_pkg::CTRL_OFS && state_reg == ispb_pkg::ST_IDLE) begin
      ctrl_reg.slow <= pwdata_i[ispb_pkg::CTRL_SLOW_BIT]; // RQ19
      ctrl_reg.clock_phase_select <= pwdata_i[ispb_pkg::CTRL_PHA_BIT];
      ctrl_reg.clock_polarity_select <= pwdata_i[ispb_pkg::CTRL_POL_BIT];
      ctrl_reg.en <= pwdata_i[ispb_pkg::CTRL_EN_BIT]; // RQ17
      ctrl_reg.role <= pwdata_i[ispb_pkg::CTRL_ROLE_BIT]; // RQ18
      ctrl_reg.len_m1 <= pwdata_i[ispb_pkg::CTRL_LEN_LSB +: 5];
    end
  end

  // transmit word, written only when idle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txdata_reg <= 32'h0000_0000;
    end else if (start) begin
      txdata_reg <= pwdata_i;
    end
  end

  // done flag: frame end sets, write one clears, set wins
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_reg <= 1'b0;
    end else if (state_reg == ispb_pkg::ST_TAIL && tmr_zero) begin
      done_reg <= 1'b1;
    end else if (apb_wr && paddr_i == ispb_pkg::STATUS_OFS
                 && pwdata_i[ispb_pkg::STATUS_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // ****************************************
  // data-in synchroniser
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      miso_meta_reg <= 1'b1;
      miso_sync_reg <= 1'b1;
    end else begin
      miso_meta_reg <= miso_i;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  assign half_cyc = ctrl_reg.slow ? ispb_pkg::TMR_W'(ispb_pkg::HALF_SLOW_CYC - 1)
                                  : ispb_pkg::TMR_W'(ispb_pkg::HALF_FAST_CYC - 1);
  assign edge_total_m1 = {ctrl_reg.len_m1, 1'b1}; // two edges per bit
  assign tmr_zero = tmr_reg == '0;
  assign leading = ~edge_reg[0];
  assign latch = leading ^ ctrl_reg.clock_phase_select;
  assign last_edge = edge_reg == edge_total_m1;

  // state and interval timer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ispb_pkg::ST_IDLE;
      tmr_reg <= '0;
    end else begin
      unique case (state_reg)
        ispb_pkg::ST_IDLE: if (start) begin
          state_reg <= ispb_pkg::ST_LEAD;
          tmr_reg <= ispb_pkg::TMR_W'(ispb_pkg::LEAD_CYC - 1); // RQ10
        end
        ispb_pkg::ST_LEAD: if (tmr_zero) begin
          state_reg <= ispb_pkg::ST_SHIFT;
          tmr_reg <= half_cyc;
        end else begin
          tmr_reg <= tmr_reg - 1'b1;
        end
        ispb_pkg::ST_SHIFT: if (!tmr_zero) begin
          tmr_reg <= tmr_reg - 1'b1;
        end else if (last_edge) begin
          state_reg <= ispb_pkg::ST_TAIL;
          tmr_reg <= ispb_pkg::TMR_W'(ispb_pkg::TAIL_CYC - 1); // RQ9
        end else begin
          tmr_reg <= half_cyc; // RQ3
        end
        ispb_pkg::ST_TAIL: if (tmr_zero) begin
          state_reg <= ispb_pkg::ST_GAP;
          tmr_reg <= ispb_pkg::TMR_W'(ispb_pkg::GAP_CYC - 1); // RQ8
        end else begin
          tmr_reg <= tmr_reg - 1'b1;
        end
        ispb_pkg::ST_GAP: if (tmr_zero) begin
          state_reg <= ispb_pkg::ST_IDLE;
        end else begin
          tmr_reg <= tmr_reg - 1'b1;
        end
      endcase
    end
  end

  // clock edges, shifting and sampling
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spi_reg <= 3'b111;
      tx_reg <= 32'h0000_0000;
      rx_reg <= 32'h0000_0000;
      edge_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        ispb_pkg::ST_IDLE: begin
          spi_reg.sck <= ctrl_reg.clock_polarity_select;
          spi_reg.cs_n <= 1'b1;
          edge_reg <= 6'h00;
          if (start) begin
            tx_reg <= pwdata_i << (5'h1F - ctrl_reg.len_m1); // msb first, left aligned
            spi_reg.mosi <= pwdata_i[ctrl_reg.len_m1];
            rx_reg <= 32'h0000_0000; // no bits of an earlier frame above the new word
            spi_reg.cs_n <= 1'b0; // select falls as the lead interval begins
          end
        end
        ispb_pkg::ST_SHIFT: if (tmr_zero) begin
          spi_reg.sck <= ~spi_reg.sck;
          edge_reg <= edge_reg + 6'h01;
          if (latch) begin
            rx_reg <= {rx_reg[30:0], miso_sync_reg}; // RQ7
          end else if (edge_reg != 6'h00) begin
            tx_reg <= {tx_reg[30:0], 1'b0};
            spi_reg.mosi <= tx_reg[30];
          end
        end
        ispb_pkg::ST_GAP: begin
          spi_reg.cs_n <= 1'b1; // RQ8
          spi_reg.mosi <= 1'b1;
        end
        default: begin
          spi_reg.cs_n <= (state_reg == ispb_pkg::ST_TAIL && tmr_zero) ? 1'b1 : spi_reg.cs_n;
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign cs_n_o = spi_reg.cs_n;
  assign sck_o = spi_reg.sck;
  assign mosi_o = spi_reg.mosi;
  assign role_select_o = ctrl_reg.role; // RQ18
  assign slow_o = ctrl_reg.slow;
  assign clock_phase_select_o = ctrl_reg.clock_phase_select;
  assign clock_polarity_select_o = ctrl_reg.clock_polarity_select;
  assign enable_o = ctrl_reg.en;

endmodule // ispb_host_ctrl

// ---- rtl/ispb_pkg.sv ----
/*
  constants, register map and types for the pulse bridge host controller.
  assumes a 100 MHz system clock and a bridge device placed in the master role.
*/
package ispb_pkg;

  // ****************************************
  // clock and link timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_FAST_NS = 250; // two halves give 0.5 us between latching edges
  localparam int HALF_SLOW_NS = 2500; // two halves give 5 us between latching edges
  localparam int LEAD_NS = 1000; // chip select fall to first latching edge
  localparam int TAIL_NS = 1000; // last latching edge to chip select rise
  localparam int GAP_NS = 2000; // chip select high between frames
  localparam int HALF_FAST_CYC = (HALF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_SLOW_CYC = (HALF_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYC = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAIL_CYC = (TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] TXDATA_OFS = 12'h004;
  localparam logic [11:0] RXDATA_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam int CTRL_SLOW_BIT = 0;
  localparam int CTRL_PHA_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_ROLE_BIT = 4;
  localparam int CTRL_LEN_LSB = 8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1F18; // 32 bits, enable and master role

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [4:0] len_m1; // frame length minus one
    logic role; // bridge role select, high is master
    logic en; // keeps the bridge awake
    logic clock_polarity_select; // clock idle level
    logic clock_phase_select; // clock phase
    logic slow; // slow link timing
  } ispb_ctrl_s;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } ispb_spi_s;

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL, ST_GAP} ispb_state_e;

endpackage // ispb_pkg

// ---- testbench/ispb_host_ctrl_asserts.sv ----
/* assertions on apb answers and serial frame timing of the host controller.
   assumes binding onto ispb_host_ctrl, one clock domain. */
module ispb_host_ctrl_asserts (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic cs_n_o,
  input wire logic sck_o,
  input wire logic slow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HF = ispb_pkg::HALF_FAST_CYC - 1;
  localparam int HS = ispb_pkg::HALF_SLOW_CYC - 1;
  localparam int TL = ispb_pkg::TAIL_CYC - 1;
  logic sck_q;
  logic seen_reg;
  logic [15:0] edge_cnt;
  logic [15:0] high_cnt;
  wire sck_chg = !cs_n_o && (sck_o != sck_q);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ****************************************
  // helper counters
  // ****************************************
  // cycles since the last clock edge in a frame
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_q <= 1'b0;
      seen_reg <= 1'b0;
      edge_cnt <= 16'h0000;
    end else begin
      sck_q <= sck_o;
      seen_reg <= !cs_n_o && (seen_reg || sck_chg);
      edge_cnt <= (cs_n_o || sck_chg) ? 16'h0000 : edge_cnt + 16'h0001;
    end
  end
  // cycles with chip select high, saturating
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_cnt <= 16'h0FFF;
    end else if (!cs_n_o) begin
      high_cnt <= 16'h0000;
    end else if (high_cnt != 16'h0FFF) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
  pready_late_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer missing in second access cycle");
  pready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("apb ready longer than one cycle");
  err_decode_a: assert property (pready_o |-> pslverr_o == (paddr_i > 12'h00C))
    else $error("apb error does not match address decode");
  err_data_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0000_0000)
    else $error("apb error without ready or with data");
  lead_time_a: assert property (sck_chg && !seen_reg |-> edge_cnt >= ispb_pkg::LEAD_CYC)
    else $error("first clock edge too soon after select");
  half_period_a: assert property (sck_chg && seen_reg |-> edge_cnt >= (slow_o ? HS : HF))
    else $error("clock edges too close");
  tail_time_a: assert property ($rose(cs_n_o) && seen_reg |-> edge_cnt >= TL)
    else $error("select raised too soon after last edge");
  gap_time_a: assert property ($fell(cs_n_o) |-> high_cnt >= ispb_pkg::GAP_CYC)
    else $error("select high gap too short");
endmodule // ispb_host_ctrl_asserts

bind ispb_host_ctrl ispb_host_ctrl_asserts i_asrt (.clk_sys_i, .reset_n_i, .psel_i, .penable_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .cs_n_o, .sck_o, .slow_o);

// ---- testbench/ispb_bridge_model.sv ----
/* behavioural bridge in the master role facing the controller.
   assumes data-out is open drain with a pull-up, so released means high. */
module ispb_bridge_model (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic role_select_i,
  input wire logic clock_phase_select_i,
  input wire logic clock_polarity_select_i,
  input wire logic [31:0] ret_word_i,
  output logic miso_o,
  output logic pair_plus_line_o,
  output logic pair_minus_line_o,
  output logic [31:0] got_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  initial begin
    miso_o = 1'b1;
    pair_plus_line_o = 1'b0;
    pair_minus_line_o = 1'b0;
    got_word_o = 32'h0000_0000;
  end
  // ****************************************
  // pulse pair and serial side
  // ****************************************
  // one bipolar pulse, first half positive when p is high
  task automatic send(input logic p, input int w);
    pair_plus_line_o = p;
    pair_minus_line_o = !p;
    #w;
    pair_plus_line_o = !p;
    pair_minus_line_o = p;
    #w;
    pair_plus_line_o = 1'b0;
    pair_minus_line_o = 1'b0;
  endtask
  // select change: long pulse, data-out released or first bit
  always @(cs_n_i) if (role_select_i) begin
    fork send(cs_n_i, 150); join_none
    idx = 0;
    if (cs_n_i) begin
      miso_o <= #40 1'b1;
    end else begin
      got_word_o = 32'h0000_0000;
      if (!clock_phase_select_i) begin
        miso_o <= #40 ret_word_i[31];
        idx = 1;
      end
    end
  end
  // latching edges send data, the others present the next returned bit
  always @(sck_i) if (role_select_i && !cs_n_i) begin
    if (sck_i == !(clock_polarity_select_i ^ clock_phase_select_i)) begin
      got_word_o = {got_word_o[30:0], mosi_i};
      fork send(mosi_i, 50); join_none
    end else begin
      miso_o <= #40 (idx < 32) ? ret_word_i[31 - idx] : 1'b1;
      idx++;
    end
  end
endmodule // ispb_bridge_model

// ---- testbench/ispb_host_ctrl_tb.sv ----
/* self-checking bench: apb driver, read scoreboard and serial frames.
   assumes the bridge model answers on the far side of the spi pins. */
module ispb_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, ret_word = 32'h0, got_word;
  logic pready, pslverr, miso, cs_n, sck, mosi, role, slow, clock_phase_select, clock_polarity_select, en;
  logic [32:0] exp_q[$];
  int err_count = 0, comparisons = 0;
  integer seed = 32'he9eb8d88;
  always #5 clk = ~clk;
  ispb_host_ctrl i_dut (.clk_sys_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .miso_i(miso), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi),
    .role_select_o(role), .slow_o(slow), .clock_phase_select_o(clock_phase_select),
    .clock_polarity_select_o(clock_polarity_select), .enable_o(en));
  ispb_bridge_model i_bridge (.cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi), .role_select_i(role),
    .clock_phase_select_i(clock_phase_select), .clock_polarity_select_i(clock_polarity_select), .ret_word_i(ret_word),
    .miso_o(miso), .pair_plus_line_o(), .pair_minus_line_o(), .got_word_o(got_word));
  // ****************************************
  // tasks, scoreboard and run sequence
  // ****************************************
  task check(input string what, input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  // straps, a refused second start, returned word and done flag
  task frame(input logic [31:0] ctrl, input int n, input logic [31:0] tx);
    ret_word = $random(seed);
    apb(1'b1, ispb_pkg::CTRL_OFS, ctrl);
    rd(ispb_pkg::CTRL_OFS, {1'b0, ctrl});
    check("straps", {28'h0, ctrl[4:0]}, {28'h0, role, en, clock_polarity_select, clock_phase_select, slow});
    apb(1'b1, ispb_pkg::TXDATA_OFS, tx);
    apb(1'b1, ispb_pkg::TXDATA_OFS, ~tx);
    apb(1'b1, ispb_pkg::CTRL_OFS, 32'h0000_0000);
    @(posedge cs_n);
    repeat (ispb_pkg::GAP_CYC + 4) @(posedge clk);
    check("sent word", {1'b0, tx & (32'hFFFF_FFFF >> (32 - n))}, {1'b0, got_word});
    rd(ispb_pkg::RXDATA_OFS, {1'b0, ret_word >> (32 - n)});
    rd(ispb_pkg::STATUS_OFS, 33'h0_0000_0002);
    apb(1'b1, ispb_pkg::STATUS_OFS, 32'h0000_0002);
    rd(ispb_pkg::STATUS_OFS, 33'h0_0000_0000);
    rd(ispb_pkg::TXDATA_OFS, {1'b0, tx});
    rd(ispb_pkg::CTRL_OFS, {1'b0, ctrl});
    $display("frame test of %0d bits done, control %h", n, ctrl);
  endtask
  // compares every read answer with the oldest note
  always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    if (exp_q.size() > 0) check("apb read", exp_q.pop_front(), {pslverr, prdata});
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    check("reset straps", 33'h0_0000_0018, {28'h0, role, en, clock_polarity_select, clock_phase_select, slow});
    rd(ispb_pkg::CTRL_OFS, {1'b0, ispb_pkg::CTRL_RESET});
    rd(ispb_pkg::STATUS_OFS, 33'h0_0000_0000);
    apb(1'b1, 12'h100, 32'h0000_0000);
    rd(12'h010, 33'h1_0000_0000);
    rd(ispb_pkg::CTRL_OFS, {1'b0, ispb_pkg::CTRL_RESET});
    $display("register test done");
    for (int m = 0; m < 4; m++) frame(32'h0000_0718 | 32'(m << 1), 8, $random(seed));
    frame(32'h0000_0719, 8, $random(seed));
    frame(32'h0000_1F18, 32, $random(seed));
    final_report();
  end
endmodule // ispb_host_ctrl_tb
